// File: logic/pci_pkg.sv
// Constants of the pin-change interrupt block
// ----------------------------------------------------------------------------
// Contract
// - Separate change enable for every pin except port A pin 4 and port B pins 3:2
// - Power-on reset clears all pin enables
// - Port A pin 5 ignored as master-clear
// - Compare pin with latch from last port read or write
// - OR all enabled mismatches into flag
// - Flag always sets; interrupt needs global enable
// - Persisting mismatch keeps setting the flag
// - Port access refreshes latch, then clear flag
// - Master-clear reset keeps the comparison latch
// - Change during port access may be missed
// - Wake from sleep only with global enable
// - Port A enable bit 4 reads zero
// - Port B enable bits 3:2 read zero
// - Analog select disables pin change detection
// ----------------------------------------------------------------------------
package pci_pkg;
    localparam int         ADDR_W          = 6;
    localparam logic [5:0] OFF_PORTA_EN    = 6'h00;
    localparam logic [5:0] OFF_PORTB_EN    = 6'h04;
    localparam logic [5:0] OFF_CTRL        = 6'h08;
    localparam logic [5:0] OFF_PORTA       = 6'h0C;
    localparam logic [5:0] OFF_PORTB       = 6'h10;
    localparam logic [5:0] OFF_ANA_SEL_A   = 6'h14;
    localparam logic [5:0] OFF_ANA_SEL_B   = 6'h18;
    localparam logic [5:0] OFF_IRQ_STAT    = 6'h1C;
    localparam logic [5:0] OFF_IRQ_MASK    = 6'h20;
    localparam logic [7:0] PORTA_EN_MASK   = 8'hEF;
    localparam logic [7:0] PORTB_EN_MASK   = 8'hF3;
    localparam logic [7:0] EN_RESET        = 8'h00;
    localparam logic [7:0] ANA_SEL_RESET   = 8'h00;
    localparam int         CTRL_GIE_BIT    = 0;
    localparam int         CTRL_FLAG_BIT   = 1;
    localparam int         CTRL_MCPIN_BIT  = 2;
    localparam int         CTRL_SLEEP_BIT  = 3;
    localparam int         MC_PIN_IDX      = 5;
    localparam int         IRQ_FLAG_BIT    = 0;
    localparam int         IRQ_WAKE_BIT    = 1;
    localparam logic [1:0] AXI_OKAY        = 2'h0;
    localparam logic [1:0] AXI_SLVERR      = 2'h2;
endpackage : pci_pkg

// File: logic/pci_pin_change.sv
// Pin-change interrupt block with AXI4-Lite registers
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ns
module pci_pin_change
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        masterClrRst_n,
    // AXI4-Lite write
    input  wire logic [5:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read
    input  wire logic [5:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Pins
    input  wire logic [7:0]  gpPortA,
    input  wire logic [7:0]  gpPortB,
    // Events
    output logic             irq,
    output logic             changeIrq,
    output logic             wakeReq
);
    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    logic [7:0] pinA1_q, pinA_q, pinB1_q, pinB_q;
    logic       mcRst1_q, mcRst_q;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pinA1_q <= 8'h00;
            pinA_q  <= 8'h00;
            pinB1_q <= 8'h00;
            pinB_q  <= 8'h00;
            mcRst1_q <= 1'b1;
            mcRst_q  <= 1'b1;
        end
        else
        begin
            pinA1_q <= gpPortA;
            pinA_q  <= pinA1_q;
            pinB1_q <= gpPortB;
            pinB_q  <= pinB1_q;
            mcRst1_q <= masterClrRst_n;
            mcRst_q  <= mcRst1_q;
        end
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite handshakes
    // ------------------------------------------------------------------------
    logic [5:0]  awAddr_q, arAddr_q;
    logic        awHave_q, wHave_q;
    logic [31:0] wData_q;
    logic [3:0]  wStrb_q;
    logic        doWrite, doRead;
    assign doWrite = awHave_q && wHave_q && !bvalid;
    assign doRead  = arvalid && arready;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            awHave_q <= 1'b0;
            wHave_q  <= 1'b0;
            awAddr_q <= 6'h00;
            wData_q  <= 32'h0000_0000;
            wStrb_q  <= 4'h0;
            awready  <= 1'b1;
            wready   <= 1'b1;
            bvalid   <= 1'b0;
            bresp    <= pci_pkg::AXI_OKAY;
        end
        else
        begin
            if (awvalid && awready)
            begin
                awAddr_q <= awaddr;
                awHave_q <= 1'b1;
                awready  <= 1'b0;
            end
            if (wvalid && wready)
            begin
                wData_q <= wdata;
                wStrb_q <= wstrb;
                wHave_q <= 1'b1;
                wready  <= 1'b0;
            end
            if (doWrite)
            begin
                awHave_q <= 1'b0;
                wHave_q  <= 1'b0;
                bvalid   <= 1'b1;
                bresp    <= known(awAddr_q) ? pci_pkg::AXI_OKAY : pci_pkg::AXI_SLVERR;
            end
            if (bvalid && bready)
            begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    function automatic logic known(input logic [5:0] a);
        known = (a <= pci_pkg::OFF_IRQ_MASK) && (a[1:0] == 2'b00);
    endfunction : known

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    logic [7:0] enA_q, enB_q, anaA_q, anaB_q;
    logic       gie_q, mcPinEn_q, sleep_q;
    logic [1:0] irqMask_q;
    logic       wrLane0;
    assign wrLane0 = doWrite && wStrb_q[0];

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            enA_q     <= pci_pkg::EN_RESET;
            enB_q     <= pci_pkg::EN_RESET;
            anaA_q    <= pci_pkg::ANA_SEL_RESET;
            anaB_q    <= pci_pkg::ANA_SEL_RESET;
            gie_q     <= 1'b0;
            mcPinEn_q <= 1'b0;
            irqMask_q <= 2'b00;
        end
        else if (wrLane0)
        begin
            if (awAddr_q == pci_pkg::OFF_PORTA_EN)
                enA_q <= wData_q[7:0] & pci_pkg::PORTA_EN_MASK;
            if (awAddr_q == pci_pkg::OFF_PORTB_EN)
                enB_q <= wData_q[7:0] & pci_pkg::PORTB_EN_MASK;
            if (awAddr_q == pci_pkg::OFF_ANA_SEL_A)
                anaA_q <= wData_q[7:0];
            if (awAddr_q == pci_pkg::OFF_ANA_SEL_B)
                anaB_q <= wData_q[7:0];
            if (awAddr_q == pci_pkg::OFF_IRQ_MASK)
                irqMask_q <= wData_q[1:0];
            if (awAddr_q == pci_pkg::OFF_CTRL)
            begin
                gie_q     <= wData_q[pci_pkg::CTRL_GIE_BIT];
                mcPinEn_q <= wData_q[pci_pkg::CTRL_MCPIN_BIT];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Change detection
    // ------------------------------------------------------------------------
    logic       portAcc;
    logic [7:0] latA_q, latB_q, liveA, liveB, mmA, mmB;
    logic       mismatch, flag_q;
    assign portAcc = (doRead && (araddr == pci_pkg::OFF_PORTA || araddr == pci_pkg::OFF_PORTB))
                  || (doWrite && (awAddr_q == pci_pkg::OFF_PORTA
                                  || awAddr_q == pci_pkg::OFF_PORTB));

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            latA_q <= 8'h00;
            latB_q <= 8'h00;
        end
        else if (portAcc)
        begin
            latA_q <= pinA_q;
            latB_q <= pinB_q;
        end
    end

    always_comb
    begin
        liveA = enA_q & ~anaA_q;
        liveA[pci_pkg::MC_PIN_IDX] = liveA[pci_pkg::MC_PIN_IDX] & ~mcPinEn_q;
        liveB = enB_q & ~anaB_q;
    end
    assign mmA = (pinA_q ^ latA_q) & liveA;
    assign mmB = (pinB_q ^ latB_q) & liveB;
    assign mismatch = (|mmA || |mmB) && !portAcc;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            flag_q <= 1'b0;
        else if (mismatch || !mcRst_q)
            flag_q <= mismatch | flag_q;
        else if (wrLane0 && awAddr_q == pci_pkg::OFF_CTRL
                 && !wData_q[pci_pkg::CTRL_FLAG_BIT])
            flag_q <= 1'b0;
    end

    // ------------------------------------------------------------------------
    // Sleep, wake and interrupt
    // ------------------------------------------------------------------------
    logic [1:0] stat_q;
    logic       rdStat;
    assign rdStat = doRead && araddr == pci_pkg::OFF_IRQ_STAT;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sleep_q <= 1'b0;
            wakeReq <= 1'b0;
        end
        else
        begin
            wakeReq <= sleep_q && flag_q && gie_q;
            if (sleep_q && flag_q && gie_q)
                sleep_q <= 1'b0;
            else if (wrLane0 && awAddr_q == pci_pkg::OFF_CTRL)
                sleep_q <= wData_q[pci_pkg::CTRL_SLEEP_BIT];
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            changeIrq <= 1'b0;
            stat_q    <= 2'b00;
            irq       <= 1'b0;
        end
        else
        begin
            changeIrq <= flag_q && gie_q;
            stat_q[pci_pkg::IRQ_FLAG_BIT] <= (mismatch && gie_q)
                || (stat_q[pci_pkg::IRQ_FLAG_BIT] && !rdStat);
            stat_q[pci_pkg::IRQ_WAKE_BIT] <= (sleep_q && flag_q && gie_q)
                || (stat_q[pci_pkg::IRQ_WAKE_BIT] && !rdStat);
            irq <= |(stat_q & irqMask_q);
        end
    end

    // ------------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------------
    logic [7:0] rdByte;
    always_comb
    begin
        case (araddr)
            pci_pkg::OFF_PORTA_EN: rdByte = enA_q;
            pci_pkg::OFF_PORTB_EN: rdByte = enB_q;
            pci_pkg::OFF_CTRL:     rdByte = {4'h0, sleep_q, mcPinEn_q, flag_q, gie_q};
            pci_pkg::OFF_PORTA:    rdByte = pinA_q;
            pci_pkg::OFF_PORTB:    rdByte = pinB_q;
            pci_pkg::OFF_ANA_SEL_A: rdByte = anaA_q;
            pci_pkg::OFF_ANA_SEL_B: rdByte = anaB_q;
            pci_pkg::OFF_IRQ_STAT: rdByte = {6'h00, stat_q};
            pci_pkg::OFF_IRQ_MASK: rdByte = {6'h00, irqMask_q};
            default:               rdByte = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= pci_pkg::AXI_OKAY;
        end
        else if (doRead)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= {24'h00_0000, rdByte};
            rresp   <= known(araddr) ? pci_pkg::AXI_OKAY : pci_pkg::AXI_SLVERR;
        end
        else if (rvalid && rready)
        begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    sequence s_access;
        portAcc;
    endsequence
    sequence s_latched;
        ##1 latA_q == $past(pinA_q) && latB_q == $past(pinB_q);
    endsequence

    a_latch_refresh: assert property (@(posedge clk) disable iff (!arst_n)
        s_access |-> s_latched) else $error("latch not refreshed on port access");
    a_flag_sets: assert property (@(posedge clk) disable iff (!arst_n)
        mismatch |=> flag_q) else $error("mismatch did not set flag");
    a_flag_sticky: assert property (@(posedge clk) disable iff (!arst_n)
        flag_q && !wrLane0 |=> flag_q) else $error("flag dropped without clear");
    a_irq_gated: assert property (@(posedge clk) disable iff (!arst_n)
        changeIrq |-> $past(gie_q)) else $error("change irq without enable");
    a_wake_gated: assert property (@(posedge clk) disable iff (!arst_n)
        wakeReq |-> $past(gie_q) && $past(flag_q)) else $error("wake without enable");
    a_clr_pin_mask: assert property (@(posedge clk) disable iff (!arst_n)
        mcPinEn_q |-> !mmA[pci_pkg::MC_PIN_IDX]) else $error("master-clear pin compared");
    a_ana_mask: assert property (@(posedge clk) disable iff (!arst_n)
        !(|(mmA & anaA_q)) && !(|(mmB & anaB_q))) else $error("analog pin compared");
    a_enA_bit4: assert property (@(posedge clk) disable iff (!arst_n)
        !enA_q[4] && enB_q[3:2] == 2'b00) else $error("unimplemented enable bit set");
endmodule : pci_pin_change

// File: bench/pci_pin_model.sv
// Pin driver model for the two general-purpose ports
`timescale 1ns/1ns
module pci_pin_model
(
    // Clock
    input  wire logic       clk,
    // Requested levels
    input  wire logic [7:0] wantA,
    input  wire logic [7:0] wantB,
    // Pins
    output logic      [7:0] pinA = 8'h00,
    output logic      [7:0] pinB = 8'h00
);
    // pins move between accesses
    // Follows the requested levels one clock later, even in an access cycle, where a change may be missed
    always @(posedge clk)
    begin
        pinA <= wantA;
        pinB <= wantB;
    end
endmodule : pci_pin_model

// File: bench/pin_change_interrupt_tb.sv
// Self-checking testbench of the pin-change block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module pin_change_interrupt_tb;
    logic        clk = 1'h0, arst_n = 1'h0, masterClrRst_n = 1'h1;
    logic [5:0]  awaddr = 6'h00, araddr = 6'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'hF;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid, irq, changeIrq, wakeReq, woke;
    logic [1:0]  bresp, rresp, lastResp;
    logic [7:0]  lvlA = 8'h00, lvlB = 8'h00, gpPortA, gpPortB;
    int          bad_count = 0, checked = 0;

    always #5 clk = ~clk;

    pci_pin_model u_pci_pin_model (.clk(clk), .wantA(lvlA), .wantB(lvlB),
        .pinA(gpPortA), .pinB(gpPortB));
    pci_pin_change u_pci_pin_change (.clk(clk), .arst_n(arst_n), .masterClrRst_n(masterClrRst_n),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .gpPortA(gpPortA), .gpPortB(gpPortB), .irq(irq), .changeIrq(changeIrq),
        .wakeReq(wakeReq));

    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic aw;
        logic w;
        aw = 1'h0;
        w = 1'h0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!(aw && w))
        begin
            @(posedge clk);
            if (awvalid && awready)
            begin
                aw = 1'h1;
                awvalid <= 1'h0;
            end
            if (wvalid && wready)
            begin
                w = 1'h1;
                wvalid <= 1'h0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'h1);
        bready <= 1'h0;
        `CHK("bresp", pci_pkg::AXI_OKAY, bresp)
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [31:0] e, input string nm);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge clk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        do @(posedge clk); while (rvalid !== 1'h1);
        rready <= 1'h0;
        lastResp = rresp;
        `CHK(nm, e, rdata)
    endtask : rd

    // Wake is a one-cycle pulse, so it is watched every edge
    task automatic watch();
        woke = 1'h0;
        repeat (30)
        begin
            @(posedge clk);
            if (wakeReq === 1'h1)
                woke = 1'h1;
        end
    endtask : watch

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial
    begin
        #100000;
        bad_count++;
        print_verdict();
    end

    initial
    begin
        repeat (12) @(posedge clk);
        arst_n <= 1'h1;
        rd(pci_pkg::OFF_PORTA_EN, 32'h0, "enA reset");
        rd(pci_pkg::OFF_PORTB_EN, 32'h0, "enB reset");
        wr(pci_pkg::OFF_PORTA_EN, 32'hFF);
        rd(pci_pkg::OFF_PORTA_EN, 32'hEF, "enA");
        wr(pci_pkg::OFF_PORTB_EN, 32'hFF);
        rd(pci_pkg::OFF_PORTB_EN, 32'hF3, "enB");
        rd(6'h24, 32'h0, "unmapped");
        `CHK("unmapped resp", pci_pkg::AXI_SLVERR, lastResp)
        // Write with byte lane 0 off must leave the enables alone
        wstrb <= 4'hE;
        wr(pci_pkg::OFF_PORTA_EN, 32'h0);
        wstrb <= 4'hF;
        rd(pci_pkg::OFF_PORTA_EN, 32'hEF, "enA lane off");
        $display("register test done");
        // Pin 5 as master clear, pin 0 analog, pin 4 has no enable
        wr(pci_pkg::OFF_CTRL, 32'h4);
        wr(pci_pkg::OFF_ANA_SEL_A, 32'h1);
        lvlA <= 8'h31;
        repeat (8) @(posedge clk);
        rd(pci_pkg::OFF_CTRL, 32'h4, "ctrl masked pins");
        lvlB <= 8'h02;
        repeat (8) @(posedge clk);
        rd(pci_pkg::OFF_CTRL, 32'h6, "ctrl flag set");
        `CHK("changeIrq off", 1'h0, changeIrq)
        wr(pci_pkg::OFF_CTRL, 32'h4);
        rd(pci_pkg::OFF_CTRL, 32'h6, "ctrl clear lost");
        rd(pci_pkg::OFF_PORTB, 32'h2, "port B");
        rd(pci_pkg::OFF_CTRL, 32'h6, "ctrl sticky");
        wr(pci_pkg::OFF_CTRL, 32'h4);
        rd(pci_pkg::OFF_CTRL, 32'h4, "ctrl cleared");
        $display("detect test done");
        wr(pci_pkg::OFF_IRQ_MASK, 32'h1);
        wr(pci_pkg::OFF_CTRL, 32'h5);
        lvlB <= 8'h00;
        repeat (8) @(posedge clk);
        `CHK("changeIrq on", 1'h1, changeIrq)
        `CHK("irq on", 1'h1, irq)
        wr(pci_pkg::OFF_IRQ_MASK, 32'h0);
        repeat (2) @(posedge clk);
        `CHK("irq masked", 1'h0, irq)
        wr(pci_pkg::OFF_IRQ_MASK, 32'h1);
        rd(pci_pkg::OFF_PORTB, 32'h0, "port B idle");
        wr(pci_pkg::OFF_CTRL, 32'h5);
        rd(pci_pkg::OFF_IRQ_STAT, 32'h1, "irq status");
        repeat (2) @(posedge clk);
        `CHK("irq cleared", 1'h0, irq)
        $display("interrupt test done");
        // Sleep without global enable must not wake
        fork
            wr(pci_pkg::OFF_CTRL, 32'hC);
            watch();
        join
        lvlB <= 8'h02;
        watch();
        `CHK("no wake", 1'h0, woke)
        rd(pci_pkg::OFF_CTRL, 32'hE, "ctrl asleep");
        fork
            wr(pci_pkg::OFF_CTRL, 32'hF);
            watch();
        join
        `CHK("wake", 1'h1, woke)
        rd(pci_pkg::OFF_CTRL, 32'h7, "ctrl awake");
        masterClrRst_n <= 1'h0;
        repeat (2) @(posedge clk);
        masterClrRst_n <= 1'h1;
        wr(pci_pkg::OFF_CTRL, 32'h5);
        rd(pci_pkg::OFF_CTRL, 32'h7, "ctrl after master_clear_pin");
        $display("sleep test done");
        print_verdict();
    end
endmodule : pin_change_interrupt_tb
